// [src/rcs_defines.vh]
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH
// ************************************************************
// Register indexes; byte address is four times the index
// ************************************************************
`define RCS_IDX_PCL 8'h02
`define RCS_IDX_STATUS 8'h03
`define RCS_IDX_RESET_CAUSE 8'h04
`define RCS_IDX_CTRL 8'h05
`define RCS_IDX_IRQ_STAT 8'h06
`define RCS_IDX_IRQ_MASK 8'h07
`define RCS_IDX_PC_HIGH 8'h08
// ************************************************************
// Field positions
// ************************************************************
`define RCS_ST_PD 3
`define RCS_ST_TO 4
`define RCS_RC_BROWNOUT 0
`define RCS_RC_POWERON 1
// ************************************************************
// Reset values and vectors
// ************************************************************
`define RCS_STATUS_POR 8'h18
`define RCS_PC_RESET 13'h0000
`define RCS_PC_IRQ_VEC 13'h0004
`define RCS_BROWNOUT_CONFIG_FIELD_OFF 2'h0
// ************************************************************
// Oscillator modes
// ************************************************************
`define RCS_OSC_LP 3'h0
`define RCS_OSC_XT 3'h1
`define RCS_OSC_HS 3'h2
`define RCS_OSC_RC 3'h3
`define RCS_OSC_EC 3'h4
`define RCS_OSC_INT 3'h5
// ************************************************************
// Timing
// ************************************************************
`define RCS_CLK_PERIOD_NS 4
`define RCS_POWER_UP_DELAY_TIMER_NS 64000000
`define RCS_POWER_UP_DELAY_TIMER_CYC (`RCS_POWER_UP_DELAY_TIMER_NS / `RCS_CLK_PERIOD_NS)
`define RCS_OST_PERIODS 1024
`endif

// [src/rcs_pin_sync.v]
`timescale 1ns/1ps
// Three sync flops and a registered output; level changes once the second and third agree
module rcs_pin_sync (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Pin
  input wire i_pin,
  output reg o_level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end
endmodule

// [src/rcs_delay_timer.v]
`timescale 1ns/1ps
// Loadable down-counter; done level when count reaches zero
module rcs_delay_timer #(
  parameter W = 24
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_start,
  input wire [W-1:0] i_count,
  input wire i_tick,
  output wire o_done
);
  reg [W-1:0] cnt_r;
  reg run_r;
  assign o_done = run_r && (cnt_r == {W{1'b0}});
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
    end else if (i_start) begin
      cnt_r <= i_count;
      run_r <= 1'b1;
    end else if (run_r && i_tick && cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// [src/rcs_sequencer.v]
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rcs_defines.vh"
// Function
// - Power-up timer starts after power-on pulse; oscillator count after it.
// - External clock with power-up timer disabled: no start-up delay.
// - Delays run from power-on; late pin release starts execution at once.
// - RC, external, internal oscillator: power-up period if enabled, else none.
// - XT, HS and LP (secondary timer oscillator off) count 1024 oscillator periods after optional power-up period.
// - Resets load program counter zero; wake-ups continue at next instruction.
// - Interrupt wake-up with global enable vectors to 0004h after next.
// - Status time-out and power-down flags per reset and wake-up source.
// - Unimplemented status and flag bits read as zero.
// - Reset-cause register: brown-out flag bit 0, power-on flag bit 1.
// - Brown-out reset clears brown-out flag, leaves power-on flag.
// - Brown-out flag is don't-care when brown-out detector is off.
// - Power-on reset clears power-on flag; other resets leave it.
// - Wake-ups change only program counter and time-out/power-down flags; watchdog wake also sets interrupt status bit 2.
module rcs_sequencer (
  // Clock and synchronous reset
  input wire I_REF_CLK,
  input wire I_RST_N,
  // Reset and wake sources (power-on pulse, brown-out, watchdog, pin)
  input wire I_POR,
  input wire I_BROWNOUT,
  input wire I_WDT_TIMEOUT,
  input wire I_EXT_RESET_PIN_N,
  input wire I_IRQ_WAKE,
  input wire I_SLEEP,
  input wire I_GIE,
  input wire I_OSC_TICK,
  // Configuration
  input wire [2:0] I_OSC_MODE,
  input wire I_POWER_UP_DELAY_ENABLE_N,
  input wire I_SECONDARY_TIMER_OSC_EN,
  input wire [1:0] I_BROWNOUT_CONFIG_FIELD,
  // Core view
  output reg O_CORE_RUN,
  output reg O_PUSH_RETURN,
  output wire [12:0] O_PC,
  output wire O_IRQ,
  // AXI4-Lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // ************************************************************
  // Sequencer states
  // ************************************************************
  localparam ST_POR = 3'd0;
  localparam ST_POWER_UP_DELAY_TIMER = 3'd1;
  localparam ST_OST = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_RUN = 3'd4;
  localparam ST_SLEEP = 3'd5;
  localparam ST_WAKE = 3'd6;
  localparam integer POWER_UP_DELAY_TIMER_CYC_I = `RCS_POWER_UP_DELAY_TIMER_CYC;
  localparam integer OST_CNT_I = `RCS_OST_PERIODS;
  localparam [23:0] POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_CYC_I[23:0];
  localparam [23:0] OST_CNT = OST_CNT_I[23:0];

  function crystal_mode;
    input [2:0] m;
    input t1;
    begin
      crystal_mode = (m == `RCS_OSC_XT) || (m == `RCS_OSC_HS) ||
        ((m == `RCS_OSC_LP) && !t1);
    end
  endfunction

  function [7:0] reg_sel;
    input [7:0] addr;
    begin
      reg_sel = {2'b00, addr[7:2]};
    end
  endfunction

  wire pin_low;
  wire por_lvl;
  wire bo_lvl;
  wire pin_asserted = !I_EXT_RESET_PIN_N;
  // Sync the asserted level so reset state matches an idle pin
  rcs_pin_sync u_sync_pin (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(pin_asserted),
    .o_level(pin_low)
  );
  rcs_pin_sync u_sync_por (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_POR),
    .o_level(por_lvl)
  );
  rcs_pin_sync u_sync_bo (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_BROWNOUT),
    .o_level(bo_lvl)
  );

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [12:0] pc_r;
  reg [7:0] status_r;
  reg poweron_flag_r;
  reg brownout_flag_r;
  reg [7:0] ctrl_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg por_d_r;
  reg bo_d_r;
  reg wdt_d_r;
  reg pin_d_r;
  reg irq_pending_r;
  reg t_start;
  reg [23:0] t_count;
  wire t_done;
  wire por_fall = por_d_r && !por_lvl;
  wire bo_rise = bo_lvl && !bo_d_r;
  wire wdt_rise = I_WDT_TIMEOUT && !wdt_d_r;
  wire pin_fall = !pin_d_r && pin_low;
  wire xtal = crystal_mode(I_OSC_MODE, I_SECONDARY_TIMER_OSC_EN);
  wire power_up_delay_timer_on = !I_POWER_UP_DELAY_ENABLE_N;

  // Power-up uses the reference clock; oscillator count uses osc ticks
  wire tick = (state_r == ST_OST || state_r == ST_WAKE) ? I_OSC_TICK : 1'b1;

  rcs_delay_timer #(.W(24)) u_timer (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_start(t_start),
    .i_count(t_count),
    .i_tick(tick),
    .o_done(t_done)
  );

  // ************************************************************
  // Start-up sequencing
  // ************************************************************
  always @* begin
    state_nxt = state_r;
    t_start = 1'b0;
    t_count = POWER_UP_DELAY_TIMER_CYC;
    case (state_r)
      ST_POR: begin
        if (!por_lvl && !bo_lvl) begin
          if (power_up_delay_timer_on) begin
            state_nxt = ST_POWER_UP_DELAY_TIMER;
            t_start = 1'b1;
          end else if (xtal) begin
            state_nxt = ST_OST;
            t_start = 1'b1;
            t_count = OST_CNT;
          end else begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_POWER_UP_DELAY_TIMER: begin
        if (t_done) begin
          if (xtal) begin
            state_nxt = ST_OST;
            t_start = 1'b1;
            t_count = OST_CNT;
          end else begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_OST: begin
        if (t_done) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!pin_low) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (I_SLEEP) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wdt_rise || I_IRQ_WAKE) begin
          if (xtal) begin
            state_nxt = ST_WAKE;
            t_start = 1'b1;
            t_count = OST_CNT;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_WAKE: begin
        if (t_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_POR;
      end
    endcase
    // Power-on or brown-out restarts the sequence; pin, or watchdog outside sleep, sends a started core back to hold
    if (por_lvl || bo_lvl) begin
      state_nxt = ST_POR;
      t_start = 1'b0;
    end else if ((wdt_rise && state_r != ST_SLEEP) || pin_low) begin
      if (state_r == ST_RUN || state_r == ST_SLEEP ||
          state_r == ST_WAKE) begin
        state_nxt = ST_HOLD;
        t_start = 1'b0;
      end
    end
  end

  // ************************************************************
  // Program counter, status and cause flags
  // ************************************************************
  wire wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  wire [7:0] wsel = reg_sel(S_AXI_AWADDR);
  wire wr_lane0 = wr_fire && S_AXI_WSTRB[0];
  wire in_sleep = (state_r == ST_SLEEP) || (state_r == ST_WAKE);
  reg [3:0] ev;

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_r <= ST_POR;
      pc_r <= `RCS_PC_RESET;
      status_r <= `RCS_STATUS_POR;
      poweron_flag_r <= 1'b0;
      brownout_flag_r <= 1'b0;
      ctrl_r <= 8'h00;
      irq_mask_r <= 4'h0;
      por_d_r <= 1'b0;
      bo_d_r <= 1'b0;
      wdt_d_r <= 1'b0;
      pin_d_r <= 1'b0;
      irq_pending_r <= 1'b0;
      O_CORE_RUN <= 1'b0;
      O_PUSH_RETURN <= 1'b0;
    end else begin
      state_r <= state_nxt;
      por_d_r <= por_lvl;
      bo_d_r <= bo_lvl;
      wdt_d_r <= I_WDT_TIMEOUT;
      pin_d_r <= pin_low;
      O_CORE_RUN <= (state_nxt == ST_RUN);
      O_PUSH_RETURN <= 1'b0;
      if (wr_lane0 && wsel == `RCS_IDX_PCL) begin
        pc_r[7:0] <= S_AXI_WDATA[7:0];
      end
      if (wr_lane0 && wsel == `RCS_IDX_PC_HIGH) begin
        pc_r[12:8] <= S_AXI_WDATA[4:0];
      end
      if (wr_lane0 && wsel == `RCS_IDX_STATUS) begin
        status_r[2:0] <= S_AXI_WDATA[2:0];
        status_r[7:5] <= S_AXI_WDATA[7:5];
      end
      if (wr_lane0 && wsel == `RCS_IDX_CTRL) begin
        ctrl_r <= S_AXI_WDATA[7:0];
      end
      if (wr_lane0 && wsel == `RCS_IDX_RESET_CAUSE) begin
        poweron_flag_r <= S_AXI_WDATA[`RCS_RC_POWERON];
        brownout_flag_r <= S_AXI_WDATA[`RCS_RC_BROWNOUT];
      end
      if (wr_lane0 && wsel == `RCS_IDX_IRQ_MASK) begin
        irq_mask_r <= S_AXI_WDATA[3:0];
      end
      if (state_r == ST_RUN && I_SLEEP) begin
        status_r[`RCS_ST_PD] <= 1'b0;
        status_r[`RCS_ST_TO] <= 1'b1;
      end
      if (por_lvl) begin
        pc_r <= `RCS_PC_RESET;
        status_r <= `RCS_STATUS_POR;
        poweron_flag_r <= 1'b0;
      end else if (bo_lvl) begin
        pc_r <= `RCS_PC_RESET;
        status_r[7:3] <= 5'h03;
        brownout_flag_r <= 1'b0;
      end else if (state_r == ST_SLEEP && wdt_rise) begin
        pc_r <= pc_r + 13'h0001;
        status_r[`RCS_ST_TO] <= 1'b0;
        status_r[`RCS_ST_PD] <= 1'b0;
      end else if (wdt_rise) begin
        pc_r <= `RCS_PC_RESET;
        status_r[7:5] <= 3'h0;
        status_r[`RCS_ST_TO] <= 1'b0;
        status_r[`RCS_ST_PD] <= 1'b1;
      end else if (pin_fall) begin
        pc_r <= `RCS_PC_RESET;
        status_r[7:5] <= 3'h0;
        if (in_sleep) begin
          status_r[`RCS_ST_TO] <= 1'b1;
          status_r[`RCS_ST_PD] <= 1'b0;
        end
      end else if (state_r == ST_SLEEP && I_IRQ_WAKE) begin
        pc_r <= pc_r + 13'h0001;
        status_r[`RCS_ST_TO] <= 1'b1;
        status_r[`RCS_ST_PD] <= 1'b0;
        irq_pending_r <= I_GIE;
      end else if (irq_pending_r && state_r == ST_RUN) begin
        // Next instruction already fetched; now push and vector
        irq_pending_r <= 1'b0;
        O_PUSH_RETURN <= 1'b1;
        pc_r <= `RCS_PC_IRQ_VEC;
      end
    end
  end

  // ************************************************************
  // Interrupt status: set wins over write-one-to-clear
  // ************************************************************
  always @* begin
    ev = {pin_fall, wdt_rise, bo_rise, por_fall};
  end
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_irq
      always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          irq_stat_r[g] <= 1'b0;
        end else if (ev[g]) begin
          irq_stat_r[g] <= 1'b1;
        end else if (wr_lane0 && wsel == `RCS_IDX_IRQ_STAT &&
                     S_AXI_WDATA[g]) begin
          irq_stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign O_IRQ = |(irq_stat_r & irq_mask_r);
  assign O_PC = pc_r;

  // ************************************************************
  // AXI4-Lite: write taken when address and data both present
  // ************************************************************
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire [7:0] rsel = reg_sel(S_AXI_ARADDR);
  // Brown-out flag masked when detector disabled: value is meaningless
  wire bo_read = (I_BROWNOUT_CONFIG_FIELD == `RCS_BROWNOUT_CONFIG_FIELD_OFF) ?
    1'b0 : brownout_flag_r;

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= 2'b00;
      S_AXI_RDATA <= 32'h00000000;
    end else begin
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wsel >= `RCS_IDX_PCL && wsel <= `RCS_IDX_PC_HIGH) ?
          2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (S_AXI_ARVALID && !S_AXI_RVALID) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'b00;
        S_AXI_RDATA <= 32'h00000000;
        case (rsel)
          `RCS_IDX_PCL: S_AXI_RDATA[7:0] <= pc_r[7:0];
          `RCS_IDX_PC_HIGH: S_AXI_RDATA[4:0] <= pc_r[12:8];
          `RCS_IDX_STATUS: S_AXI_RDATA[7:0] <= status_r;
          `RCS_IDX_RESET_CAUSE: begin
            S_AXI_RDATA[`RCS_RC_POWERON] <= poweron_flag_r;
            S_AXI_RDATA[`RCS_RC_BROWNOUT] <= bo_read;
          end
          `RCS_IDX_CTRL: S_AXI_RDATA[7:0] <= ctrl_r;
          `RCS_IDX_IRQ_STAT: S_AXI_RDATA[3:0] <= irq_stat_r;
          `RCS_IDX_IRQ_MASK: S_AXI_RDATA[3:0] <= irq_mask_r;
          default: S_AXI_RRESP <= 2'b10;
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// [bench/rcs_seq_props.sv]
`timescale 1ns/1ps
`include "rcs_defines.vh"
module rcs_seq_props (
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_RST_N,
  // Sources and configuration
  input wire I_POR,
  input wire I_EXT_RESET_PIN_N,
  input wire I_WDT_TIMEOUT,
  input wire I_SLEEP,
  input wire [2:0] I_OSC_MODE,
  input wire I_POWER_UP_DELAY_ENABLE_N,
  // Core view
  input wire O_CORE_RUN,
  input wire O_PUSH_RETURN,
  input wire [12:0] O_PC,
  // Register bus
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  wire ec_now = I_OSC_MODE == `RCS_OSC_EC && I_POWER_UP_DELAY_ENABLE_N &&
    I_EXT_RESET_PIN_N && !I_SLEEP;
  // ************************************************************
  // Properties
  // ************************************************************
  property p_por_hold;
    I_POR [*8] |-> !O_CORE_RUN && O_PC == `RCS_PC_RESET;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("core runs during power-on pulse");
  property p_pin_hold;
    !I_EXT_RESET_PIN_N [*8] |-> !O_CORE_RUN;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("core runs while pin held low");
  property p_ec_start;
    $fell(I_POR) && ec_now |-> ##[1:12] O_CORE_RUN;
  endproperty
  a_ec_start: assert property (p_ec_start)
    else $error("external clock start delayed");
  property p_xtal_wait;
    $fell(I_POR) && I_OSC_MODE == `RCS_OSC_XT |-> !O_CORE_RUN [*8];
  endproperty
  a_xtal_wait: assert property (p_xtal_wait)
    else $error("crystal start without count");
  property p_wdt_pc;
    $rose(I_WDT_TIMEOUT) && O_CORE_RUN && !I_SLEEP |->
      ##[1:6] O_PC == `RCS_PC_RESET;
  endproperty
  a_wdt_pc: assert property (p_wdt_pc)
    else $error("watchdog reset left pc");
  property p_push_pulse;
    O_PUSH_RETURN |=> !O_PUSH_RETURN;
  endproperty
  a_push_pulse: assert property (p_push_pulse)
    else $error("push longer than one cycle");
  property p_push_vec;
    O_PUSH_RETURN |-> ##[0:2] O_PC == `RCS_PC_IRQ_VEC;
  endproperty
  a_push_vec: assert property (p_push_vec)
    else $error("no interrupt vector after push");
  property p_rd_hi;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("unused read bits not zero");
  property p_rd_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped");
  property p_wr_resp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=>
      S_AXI_BVALID;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("no write response");
  c_run: cover property ($rose(O_CORE_RUN));
  c_push: cover property (O_PUSH_RETURN);
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule
bind rcs_sequencer rcs_seq_props u_props (.*);

// [bench/tb.sv]
`timescale 1ns/1ps
`include "rcs_defines.vh"
module tb;
  // Sources and configuration
  logic I_REF_CLK = 0, I_RST_N = 0, I_POR = 0, I_BROWNOUT = 0;
  logic I_WDT_TIMEOUT = 0, I_EXT_RESET_PIN_N = 1, I_IRQ_WAKE = 0;
  logic I_SLEEP = 0, I_GIE = 0, I_OSC_TICK = 0;
  logic [2:0] I_OSC_MODE = `RCS_OSC_EC;
  logic I_POWER_UP_DELAY_ENABLE_N = 1, I_SECONDARY_TIMER_OSC_EN = 0;
  logic [1:0] I_BROWNOUT_CONFIG_FIELD = 2'h1;
  logic O_CORE_RUN, O_PUSH_RETURN, O_IRQ;
  logic [12:0] O_PC;
  // Register bus
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB = 0;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, seen, pv;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  integer error_cnt = 0, checks_done = 0, nc;
  rcs_sequencer DUT (.*);
  initial forever #2 I_REF_CLK = ~I_REF_CLK;
  // Oscillator period is two core clocks
  always @(posedge I_REF_CLK) I_OSC_TICK <= ~I_OSC_TICK;
  // ************************************************************
  // Helpers
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge I_REF_CLK);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w, da, dw;
    da = 0;
    dw = 0;
    @(posedge I_REF_CLK);
    S_AXI_AWADDR <= idx << 2;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= 4'hf;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    while (!(da && dw)) begin
      @(negedge I_REF_CLK);
      a = !da && S_AXI_AWREADY;
      w = !dw && S_AXI_WREADY;
      @(posedge I_REF_CLK);
      if (a) S_AXI_AWVALID <= 0;
      if (w) S_AXI_WVALID <= 0;
      da = da | a;
      dw = dw | w;
    end
    do @(negedge I_REF_CLK); while (S_AXI_BVALID !== 1'b1);
    rsp = S_AXI_BRESP;
    @(posedge I_REF_CLK);
    S_AXI_BREADY <= 0;
  endtask
  task rdr(input logic [7:0] idx);
    @(posedge I_REF_CLK);
    S_AXI_ARADDR <= idx << 2;
    S_AXI_ARVALID <= 1;
    do @(negedge I_REF_CLK); while (S_AXI_ARREADY !== 1'b1);
    @(posedge I_REF_CLK);
    S_AXI_ARVALID <= 0;
    do @(negedge I_REF_CLK); while (S_AXI_RVALID !== 1'b1);
    // Late ready: answer must stand until taken
    @(posedge I_REF_CLK);
    S_AXI_RREADY <= 1;
    @(negedge I_REF_CLK);
    rd = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    @(posedge I_REF_CLK);
    S_AXI_RREADY <= 0;
  endtask
  task wrun(input integer lim);
    nc = 0;
    while (O_CORE_RUN !== 1'b1 && nc < lim) begin
      @(negedge I_REF_CLK);
      nc++;
    end
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset;
    rdr(`RCS_IDX_STATUS);
    chk(rd, `RCS_STATUS_POR);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h0);
    rdr(8'h30);
    chk(rsp, 2'h2);
    wr(8'h30, 8'h55);
    chk(rsp, 2'h2);
  endtask
  task t_ec_irq;
    cyc(1);
    I_POR <= 1;
    cyc(10);
    I_POR <= 0;
    wrun(40);
    chk(nc < 12, 1);
    chk(O_PC, `RCS_PC_RESET);
    rdr(`RCS_IDX_IRQ_STAT);
    chk(rd[0], 1'b1);
    chk(O_IRQ, 1'b0);
    wr(`RCS_IDX_IRQ_MASK, 8'h0f);
    @(negedge I_REF_CLK) chk(O_IRQ, 1'b1);
    wr(`RCS_IDX_IRQ_STAT, 8'h0f);
    @(negedge I_REF_CLK) chk(O_IRQ, 1'b0);
    rdr(`RCS_IDX_IRQ_STAT);
    chk(rd, 32'h0);
  endtask
  task t_sw_flags;
    wr(`RCS_IDX_RESET_CAUSE, 8'h03);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h3);
    I_BROWNOUT_CONFIG_FIELD <= 2'h0;
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h2);
    I_BROWNOUT_CONFIG_FIELD <= 2'h1;
  endtask
  task t_wdt;
    I_WDT_TIMEOUT <= 1;
    cyc(2);
    I_WDT_TIMEOUT <= 0;
    cyc(8);
    wrun(40);
    chk(O_CORE_RUN, 1'b1);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h08);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h3);
    rdr(`RCS_IDX_IRQ_STAT);
    chk(rd[2], 1'b1);
  endtask
  task t_irq_wake;
    I_GIE <= 1;
    I_SLEEP <= 1;
    cyc(4);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h10);
    I_IRQ_WAKE <= 1;
    cyc(1);
    I_IRQ_WAKE <= 0;
    I_SLEEP <= 0;
    seen = 0;
    pv = 0;
    repeat (12) begin
      @(negedge I_REF_CLK);
      seen = seen | (O_PUSH_RETURN === 1'b1);
      pv = pv | (O_PC === `RCS_PC_IRQ_VEC);
    end
    chk({seen, pv}, 2'b11);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h10);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h3);
  endtask
  task t_wdt_wake;
    I_SLEEP <= 1;
    cyc(4);
    I_WDT_TIMEOUT <= 1;
    I_SLEEP <= 0;
    cyc(2);
    I_WDT_TIMEOUT <= 0;
    cyc(10);
    chk(O_PC, 13'h0005);
    chk(O_CORE_RUN, 1'b1);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h00);
  endtask
  task t_pin_sleep;
    I_SLEEP <= 1;
    cyc(4);
    I_EXT_RESET_PIN_N <= 0;
    cyc(12);
    I_SLEEP <= 0;
    I_EXT_RESET_PIN_N <= 1;
    wrun(40);
    chk(O_CORE_RUN, 1'b1);
    chk(O_PC, `RCS_PC_RESET);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h10);
  endtask
  task t_bor_xtal;
    I_OSC_MODE <= `RCS_OSC_XT;
    I_BROWNOUT <= 1;
    cyc(10);
    I_BROWNOUT <= 0;
    wrun(2200);
    chk(nc >= 2040 && nc < 2070, 1);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h2);
    rdr(`RCS_IDX_STATUS);
    chk(rd, 32'h18);
  endtask
  task t_pin_late;
    I_EXT_RESET_PIN_N <= 0;
    I_POR <= 1;
    cyc(10);
    I_POR <= 0;
    cyc(3000);
    chk(O_CORE_RUN, 1'b0);
    I_EXT_RESET_PIN_N <= 1;
    wrun(40);
    chk(nc < 12, 1);
    rdr(`RCS_IDX_RESET_CAUSE);
    chk(rd, 32'h0);
  endtask
  task test_done;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(6);
    I_RST_N <= 1;
    cyc(10);
    t_reset;
    t_ec_irq;
    t_sw_flags;
    t_wdt;
    t_irq_wake;
    t_wdt_wake;
    t_pin_sleep;
    t_bor_xtal;
    t_pin_late;
    test_done;
  end
  // Whole run needs well under ten thousand cycles
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end
endmodule
